// file: output_monitor_command_handler.sv
// Output monitor and force command handler with AXI4-Lite registers
`timescale 1ns/100ps
module output_monitor_command_handler
    import out_monitor_pkg::*;
#(
    parameter int MS_TICKS = MS_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Command port
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [2:0] cmdCode,
    input wire logic [3:0] cmdDigits,
    input wire logic [8:0] cmdBits,
    // Reply byte stream
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txData,
    // Amplifier output lines (pins), bit 0 alarm .. bit 6 code line 3
    input wire logic [6:0] ampLines,
    // Program engine
    input wire logic positioningDone,
    input wire logic [7:0] progOutputs,
    input wire logic [15:0] progStep,
    input wire logic eventWaitStart,
    input wire logic eventWaitActive,
    // Module output pins, bit 0 positioning done, bits 8:1 prog outputs
    output logic [8:0] moduleOut,
    // Interrupt
    output logic irq,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    reply_state_t state_reg;
    logic [6:0] ampMeta_reg, ampSync_reg;
    logic [2:0] code_reg;
    logic errReply_reg;
    logic [15:0] snap_reg;
    logic [4:0] idx_reg;
    logic forceOn_reg;
    logic [8:0] forceVal_reg, moduleOut_reg;
    logic [15:0] msCount_reg;
    logic [13:0] tick_reg;
    logic outEnable_reg;
    logic [1:0] status_reg, mask_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // Two flops on the amplifier pins, only the second is read
    always_ff @(posedge clock)
    begin
        ampMeta_reg <= srst ? 7'h00 : ampLines;
        ampSync_reg <= srst ? 7'h00 : ampMeta_reg;
    end

    // Command acceptance and decode
    wire cmdTake = cmdValid & cmdReady;
    wire forceShort = (cmdCode == CMD_FORCE) && (cmdDigits < FORCE_DIGITS);
    wire cmdBad = forceShort || (cmdCode == 3'h7);
    wire forceApply = cmdTake && (cmdCode == CMD_FORCE) && !forceShort;
    wire forceRelease = cmdTake && (cmdCode == CMD_FORCE_END);
    wire [8:0] normalOut = {progOutputs, positioningDone};
    assign cmdReady = (state_reg == ST_IDLE);

    // Snapshot of the monitored value at acceptance
    wire [15:0] snapNext =
        (cmdCode == CMD_AMP_MON) ? {9'h000, ampSync_reg} :
        (cmdCode == CMD_MOD_MON) ? {7'h00, moduleOut_reg} :
        (cmdCode == CMD_PROG_MON) ? {8'h00, progOutputs} :
        (cmdCode == CMD_STEP_MON) ? progStep :
        (cmdCode == CMD_TIME_MON) ? msCount_reg : 16'h0000;

    // Reply layout: name, separator, field, CR LF
    wire isAck = errReply_reg || (code_reg == CMD_FORCE) || (code_reg == CMD_FORCE_END);
    wire isDec = (code_reg == CMD_STEP_MON) || (code_reg == CMD_TIME_MON);
    wire [55:0] nameWord =
        errReply_reg ? NAME_ERR :
        isAck ? NAME_OK :
        (code_reg == CMD_AMP_MON) ? NAME_AMP :
        (code_reg == CMD_MOD_MON) ? NAME_MOD :
        (code_reg == CMD_PROG_MON) ? NAME_PROG :
        (code_reg == CMD_STEP_MON) ? NAME_STEP : NAME_TIME;
    wire [4:0] nameLen =
        errReply_reg ? 5'd4 : isAck ? 5'd2 :
        (code_reg == CMD_STEP_MON) ? 5'd7 : (code_reg == CMD_TIME_MON) ? 5'd6 : 5'd4;
    wire [4:0] sepLen = isAck ? 5'd0 : (code_reg == CMD_PROG_MON) ? 5'd1 : 5'd3;
    wire [4:0] fieldLen =
        isAck ? 5'd0 : isDec ? 5'd5 : (code_reg == CMD_MOD_MON) ? 5'd9 : 5'd8;
    wire [4:0] fieldStart = nameLen + sepLen;
    wire [4:0] crPos = fieldStart + fieldLen;
    wire [4:0] sepOff = idx_reg - nameLen;
    wire [4:0] fieldOff = idx_reg - fieldStart;
    wire [4:0] bitPos = fieldLen - 5'd1 - fieldOff;

    function automatic logic [19:0] toBcd(input logic [15:0] bin);
        logic [19:0] bcd;
        bcd = 20'h00000;
        for (int i = 15; i >= 0; i--)
        begin
            for (int d = 0; d < 5; d++)
            begin
                if (bcd[d*4 +: 4] > 4'd4)
                    bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'd3;
            end
            bcd = {bcd[18:0], bin[i]};
        end
        return bcd;
    endfunction : toBcd

    wire [19:0] bcdVal = toBcd(snap_reg);
    wire [55:0] nameShift = nameWord << {idx_reg, 3'b000};
    wire [19:0] bcdShift = bcdVal << {fieldOff, 2'b00};
    wire [7:0] binChar = CH_ZERO | {7'h00, snap_reg[bitPos[3:0]]};
    wire [7:0] decChar = CH_ZERO + {4'h0, bcdShift[19:16]};
    wire [7:0] sepChar = (sepLen == 5'd3 && sepOff == 5'd1) ? CH_EQUAL : CH_SPACE;
    wire [7:0] curChar =
        (idx_reg < nameLen) ? nameShift[55:48] :
        (idx_reg < fieldStart) ? sepChar :
        (idx_reg < crPos) ? (isDec ? decChar : binChar) :
        (idx_reg == crPos) ? CH_CR : CH_LF;
    wire lastChar = (idx_reg == crPos + 5'd1);
    wire txFire = txValid & txReady;

    // Reply sequencer
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            code_reg <= 3'h0;
            errReply_reg <= 1'b0;
            snap_reg <= 16'h0000;
            idx_reg <= 5'h00;
            txData <= 8'h00;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cmdTake)
                    begin
                        state_reg <= ST_SEND;
                        code_reg <= cmdCode;
                        errReply_reg <= cmdBad;
                        snap_reg <= snapNext;
                        idx_reg <= 5'h00;
                    end
                end
                ST_SEND:
                begin
                    if (txFire)
                        idx_reg <= idx_reg + 5'd1;
                    if (txFire && lastChar)
                        state_reg <= ST_IDLE;
                end
            endcase
            txData <= curChar;
        end
    end
    // Data register trails the index by a cycle, so the host leaves a cycle between bytes
    assign txValid = (state_reg == ST_SEND);

    // Force state and module output pins
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            forceOn_reg <= 1'b0;
            forceVal_reg <= 9'h000;
            moduleOut_reg <= 9'h000;
        end
        else
        begin
            if (forceApply)
            begin
                forceOn_reg <= 1'b1;
                forceVal_reg <= cmdBits;
            end
            else if (forceRelease)
                forceOn_reg <= 1'b0;
            moduleOut_reg <= !outEnable_reg ? 9'h000 : forceOn_reg ? forceVal_reg : normalOut;
        end
    end
    assign moduleOut = moduleOut_reg;

    // Event timer in ms, restart wins over counting
    wire msTick = (tick_reg == 14'(MS_TICKS - 1));
    always_ff @(posedge clock)
    begin
        if (srst || eventWaitStart)
        begin
            tick_reg <= 14'h0000;
            msCount_reg <= 16'h0000;
        end
        else if (eventWaitActive)
        begin
            tick_reg <= msTick ? 14'h0000 : tick_reg + 14'd1;
            if (msTick && msCount_reg != MS_MAX)
                msCount_reg <= msCount_reg + 16'd1;
        end
    end

    // AXI4-Lite: address and data taken together, one outstanding each way
    wire wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    wire rdTake = s_axi_arvalid & ~rvalid_reg;
    wire wrLow = wrTake & s_axi_wstrb[0];
    wire wrMapped = (s_axi_awaddr <= REG_STEP) && (s_axi_awaddr[1:0] == 2'b00);
    wire rdMapped = (s_axi_araddr <= REG_STEP) && (s_axi_araddr[1:0] == 2'b00);
    wire [1:0] events = {cmdTake & cmdBad, txFire & lastChar};
    wire [1:0] w1c = (wrLow && s_axi_awaddr == REG_STATUS) ? s_axi_wdata[1:0] : 2'h0;
    wire [31:0] rdMux =
        (s_axi_araddr == REG_CTRL) ? {31'h0, outEnable_reg} :
        (s_axi_araddr == REG_STATUS) ? {30'h0, status_reg} :
        (s_axi_araddr == REG_MASK) ? {30'h0, mask_reg} :
        (s_axi_araddr == REG_FORCE) ? {22'h0, forceOn_reg, forceVal_reg} :
        (s_axi_araddr == REG_EVENT_TIME) ? {16'h0, msCount_reg} :
        (s_axi_araddr == REG_STEP) ? {16'h0, progStep} : 32'h0;
    assign s_axi_awready = wrTake;
    assign s_axi_wready = wrTake;
    assign s_axi_arready = rdTake;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            outEnable_reg <= CTRL_RESET;
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h0;
        end
        else
        begin
            if (wrLow && s_axi_awaddr == REG_CTRL)
                outEnable_reg <= s_axi_wdata[0];
            if (wrLow && s_axi_awaddr == REG_MASK)
                mask_reg <= s_axi_wdata[1:0];
            // Set beats clear in the same cycle
            status_reg <= (status_reg & ~w1c) | events;
            if (wrTake)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wrMapped ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
            if (rdTake)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rdMapped ? 2'b00 : 2'b10;
                rdata_reg <= rdMux;
            end
            else if (s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign irq = |(status_reg & mask_reg);

    // Checks
    force_apply_a: assert property (@(posedge clock) disable iff (srst)
        forceApply |=> forceOn_reg && forceVal_reg == $past(cmdBits))
        else $error("force not applied");
    force_reject_a: assert property (@(posedge clock) disable iff (srst)
        cmdTake && forceShort |=> $stable(forceVal_reg) && $stable(forceOn_reg) && errReply_reg)
        else $error("short force changed outputs");
    force_release_a: assert property (@(posedge clock) disable iff (srst)
        forceRelease |=> !forceOn_reg ##1 (moduleOut == (outEnable_reg ? $past(normalOut) : 9'h000)))
        else $error("force not released");
    reply_start_a: assert property (@(posedge clock) disable iff (srst)
        cmdTake |=> txValid && idx_reg == 5'h00 && !cmdReady)
        else $error("reply did not start");
    amp_top_bit_a: assert property (@(posedge clock) disable iff (srst)
        txValid && code_reg == CMD_AMP_MON && !errReply_reg && idx_reg == fieldStart
        |-> curChar == CH_ZERO)
        else $error("amp bit 7 not zero");
    prog_sep_a: assert property (@(posedge clock) disable iff (srst)
        txValid && code_reg == CMD_PROG_MON && idx_reg == 5'd4 |-> curChar == CH_SPACE)
        else $error("prog monitor separator wrong");
    line_end_a: assert property (@(posedge clock) disable iff (srst)
        txFire && idx_reg == crPos |=> curChar == CH_LF && lastChar)
        else $error("line end wrong");
    ms_restart_a: assert property (@(posedge clock) disable iff (srst)
        eventWaitStart |=> msCount_reg == 16'h0000)
        else $error("event timer not restarted");
    ms_saturate_a: assert property (@(posedge clock) disable iff (srst)
        msCount_reg == MS_MAX && !eventWaitStart |=> msCount_reg == MS_MAX)
        else $error("event timer wrapped");
    time_snap_a: assert property (@(posedge clock) disable iff (srst)
        cmdTake && cmdCode == CMD_TIME_MON |=> snap_reg == $past(msCount_reg))
        else $error("event time snapshot wrong");
    irq_level_a: assert property (@(posedge clock) disable iff (srst)
        (events & mask_reg) != 2'h0 && !(wrLow && s_axi_awaddr == REG_MASK) |=> irq)
        else $error("irq level wrong");
    force_cov: cover property (@(posedge clock) forceApply ##[1:300] forceRelease);
    error_cov: cover property (@(posedge clock) cmdTake && forceShort);
    decimal_cov: cover property (@(posedge clock) txFire && lastChar && isDec);
endmodule : output_monitor_command_handler

// file: out_monitor_pkg.sv
// Shared constants for the output monitor command handler
package out_monitor_pkg;
    // Command codes on the command port
    localparam logic [2:0] CMD_AMP_MON = 3'h0;
    localparam logic [2:0] CMD_MOD_MON = 3'h1;
    localparam logic [2:0] CMD_FORCE = 3'h2;
    localparam logic [2:0] CMD_FORCE_END = 3'h3;
    localparam logic [2:0] CMD_PROG_MON = 3'h4;
    localparam logic [2:0] CMD_STEP_MON = 3'h5;
    localparam logic [2:0] CMD_TIME_MON = 3'h6;
    localparam logic [3:0] FORCE_DIGITS = 4'h9;
    // Reply words, left aligned, ASCII
    localparam logic [55:0] NAME_AMP = 56'h4f555431000000;
    localparam logic [55:0] NAME_MOD = 56'h4f555432000000;
    localparam logic [55:0] NAME_PROG = 56'h504f5554000000;
    localparam logic [55:0] NAME_STEP = 56'h50474d53544550;
    localparam logic [55:0] NAME_TIME = 56'h455654494d4500;
    localparam logic [55:0] NAME_OK = 56'h4f4b0000000000;
    localparam logic [55:0] NAME_ERR = 56'h45353645000000;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_EQUAL = 8'h3d;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_FORCE = 8'h0c;
    localparam logic [7:0] REG_EVENT_TIME = 8'h10;
    localparam logic [7:0] REG_STEP = 8'h14;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [15:0] MS_MAX = 16'hffff;
    localparam int CLOCK_HZ = 10000000;
    localparam int MS_PER_SEC = 1000;
    localparam int MS_CYCLES = CLOCK_HZ / MS_PER_SEC;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} reply_state_t;
endpackage : out_monitor_pkg

// file: host_reply_sink.sv
// Reply byte sink standing for the host controller on the command link
`timescale 1ns/100ps
module host_reply_sink
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Reply stream
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    // Pacing
    input wire logic stall
);
    logic [1:0] waitCnt;
    logic [7:0] rxQ[$];
    // Never ready on a byte's first cycle, so the data has settled when taken
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            txReady <= 1'b0;
            waitCnt <= 2'h0;
        end
        else
        begin
            if (txValid && txReady)
                rxQ.push_back(txData);
            waitCnt <= (txValid && !txReady && stall && waitCnt != 2'h3) ? waitCnt + 2'h1 : 2'h0;
            txReady <= txValid && !txReady && (!stall || waitCnt == 2'h3);
        end
    end
endmodule : host_reply_sink

// file: test_output_monitor_command_handler.sv
// Self-checking testbench for the output monitor command handler
`timescale 1ns/100ps
module test_output_monitor_command_handler
    import out_monitor_pkg::*;
;
    localparam int TIMEOUT_CYCLES = 90000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdReady;
    logic [2:0] cmdCode = 3'h0;
    logic [3:0] cmdDigits = 4'h0;
    logic [8:0] cmdBits = 9'h000;
    logic txValid;
    logic txReady;
    logic [7:0] txData;
    logic [6:0] ampLines = 7'h5a;
    logic positioningDone = 1'b1;
    logic [7:0] progOutputs = 8'ha6;
    logic [15:0] progStep = 16'h04d2;
    logic eventWaitStart = 1'b0;
    logic eventWaitActive = 1'b0;
    logic [8:0] moduleOut;
    logic irq;
    logic stall = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int errors = 0;
    int nTests = 0;
    int cycles = 0;
    logic [7:0] expQ[$];
    logic [31:0] rd;
    logic [1:0] rr;

    // One tick per cycle, so saturation is reachable in a short run
    output_monitor_command_handler #(.MS_TICKS(1)) i_dut (.clock(clock), .srst(srst),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdDigits(cmdDigits),
        .cmdBits(cmdBits), .txValid(txValid), .txReady(txReady), .txData(txData),
        .ampLines(ampLines), .positioningDone(positioningDone), .progOutputs(progOutputs),
        .progStep(progStep), .eventWaitStart(eventWaitStart),
        .eventWaitActive(eventWaitActive), .moduleOut(moduleOut), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    host_reply_sink i_host (.clock(clock), .srst(srst), .txValid(txValid),
        .txReady(txReady), .txData(txData), .stall(stall));

    always #50 clock = ~clock;

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : printVerdict

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            errors++;
            $display("Error at %0t: run did not finish", $time);
            printVerdict();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        nTests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_reply(input string what);
        logic bad;
        nTests++;
        bad = (i_host.rxQ.size() != expQ.size());
        foreach (expQ[i])
            if (!bad && i_host.rxQ[i] !== expQ[i])
                bad = 1'b1;
        if (bad)
        begin
            errors++;
            $display("Error at %0t: reply to %s differs", $time, what);
        end
        i_host.rxQ.delete();
        expQ.delete();
    endtask : check_reply

    // Separator 0 none, 1 space, 2 " = "; width 0 is five decimal digits, -1 no field
    function automatic void build(input logic [55:0] n, input int sep, input logic [15:0] v,
        input int w);
        int d;
        d = 10000;
        for (int i = 6; i >= 0; i--)
            if (n[i*8 +: 8] != 8'h00)
                expQ.push_back(n[i*8 +: 8]);
        if (sep != 0)
            expQ.push_back(CH_SPACE);
        if (sep == 2)
            expQ.push_back(CH_EQUAL);
        if (sep == 2)
            expQ.push_back(CH_SPACE);
        for (int i = w - 1; i >= 0; i--)
            expQ.push_back(CH_ZERO + {7'h00, v[i]});
        for (int i = 0; i < 5 && w == 0; i++)
        begin
            expQ.push_back(CH_ZERO + 8'((v / d) % 10));
            d = d / 10;
        end
        expQ.push_back(CH_CR);
        expQ.push_back(CH_LF);
    endfunction : build

    // Offers a command and waits until the whole reply has been taken
    task automatic run_cmd(input logic [2:0] c, input logic [3:0] dg, input logic [8:0] b);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdDigits <= dg;
        cmdBits <= b;
        do @(posedge clock); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        do @(posedge clock); while (i_host.rxQ.size() == 0 || i_host.rxQ[$] !== CH_LF);
        @(posedge clock);
    endtask : run_cmd

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic test_registers();
        axi_read(REG_CTRL);
        check_val(rd, 32'h00000001, "ctrl reset");
        axi_read(REG_MASK);
        check_val(rd, 32'h00000000, "mask reset");
        axi_read(8'h40);
        check_val({rr, rd[29:0]}, 32'h80000000, "unmapped read");
        axi_write(8'h40, 32'h00000001);
        check_val({30'h0, rr}, 32'h00000002, "unmapped write");
        axi_read(REG_STEP);
        check_val(rd, 32'h000004d2, "step register");
        $display("Test registers done");
    endtask : test_registers

    task automatic test_monitors();
        run_cmd(CMD_AMP_MON, 4'h0, 9'h000);
        build(NAME_AMP, 2, 16'h005a, 8);
        check_reply("amp monitor");
        axi_read(REG_STATUS);
        check_val(rd, 32'h00000001, "reply done");
        check_val({31'h0, irq}, 32'h00000000, "irq masked");
        axi_write(REG_MASK, 32'h00000001);
        check_val({30'h0, rr}, 32'h00000000, "write okay");
        check_val({31'h0, irq}, 32'h00000001, "irq raised");
        axi_write(REG_STATUS, 32'h00000001);
        check_val({31'h0, irq}, 32'h00000000, "irq cleared");
        axi_write(REG_MASK, 32'h00000000);
        run_cmd(CMD_PROG_MON, 4'h0, 9'h000);
        build(NAME_PROG, 1, 16'h00a6, 8);
        check_reply("prog monitor");
        run_cmd(CMD_STEP_MON, 4'h0, 9'h000);
        build(NAME_STEP, 2, 16'd1234, 0);
        check_reply("step monitor");
        $display("Test monitors done");
    endtask : test_monitors

    task automatic test_force();
        stall <= 1'b1;
        run_cmd(CMD_MOD_MON, 4'h0, 9'h000);
        build(NAME_MOD, 2, 16'h014d, 9);
        check_reply("module monitor");
        stall <= 1'b0;
        run_cmd(CMD_FORCE, FORCE_DIGITS, 9'h0b2);
        build(NAME_OK, 0, 16'h0000, -1);
        check_reply("force");
        check_val({23'h0, moduleOut}, 32'h000000b2, "forced pins");
        axi_read(REG_FORCE);
        check_val(rd, 32'h000002b2, "force register");
        run_cmd(CMD_MOD_MON, 4'h0, 9'h000);
        build(NAME_MOD, 2, 16'h00b2, 9);
        check_reply("forced monitor");
        axi_write(REG_MASK, 32'h00000002);
        run_cmd(CMD_FORCE, 4'h8, 9'h1ff);
        build(NAME_ERR, 0, 16'h0000, -1);
        check_reply("short force");
        check_val({23'h0, moduleOut}, 32'h000000b2, "pins kept");
        axi_read(REG_STATUS);
        check_val(rd & 32'h00000002, 32'h00000002, "error flag");
        check_val({31'h0, irq}, 32'h00000001, "error irq");
        axi_write(REG_MASK, 32'h00000000);
        run_cmd(3'h7, 4'h0, 9'h000);
        build(NAME_ERR, 0, 16'h0000, -1);
        check_reply("unknown code");
        run_cmd(CMD_FORCE_END, 4'h0, 9'h000);
        build(NAME_OK, 0, 16'h0000, -1);
        check_reply("force end");
        check_val({23'h0, moduleOut}, 32'h0000014d, "released pins");
        axi_write(REG_CTRL, 32'h00000000);
        @(posedge clock);
        check_val({23'h0, moduleOut}, 32'h00000000, "pins disabled");
        axi_write(REG_CTRL, 32'h00000001);
        $display("Test force done");
    endtask : test_force

    task automatic test_event();
        @(posedge clock);
        eventWaitStart <= 1'b1;
        @(posedge clock);
        eventWaitStart <= 1'b0;
        eventWaitActive <= 1'b1;
        repeat (10) @(posedge clock);
        eventWaitActive <= 1'b0;
        run_cmd(CMD_TIME_MON, 4'h0, 9'h000);
        build(NAME_TIME, 2, 16'd10, 0);
        check_reply("event time");
        eventWaitActive <= 1'b1;
        repeat (65540) @(posedge clock);
        eventWaitActive <= 1'b0;
        axi_read(REG_EVENT_TIME);
        check_val(rd, 32'h0000ffff, "saturated time");
        eventWaitStart <= 1'b1;
        @(posedge clock);
        eventWaitStart <= 1'b0;
        axi_read(REG_EVENT_TIME);
        check_val(rd, 32'h00000000, "restarted time");
        $display("Test event done");
    endtask : test_event

    initial
    begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        test_registers();
        repeat (4) @(posedge clock);
        test_monitors();
        test_force();
        test_event();
        printVerdict();
    end
endmodule : test_output_monitor_command_handler
